// ==== src/dcvs_addr_match.sv ====
`timescale 1ns/1ps
module dcvs_addr_match (
    // stored address variables
    input  wire logic [7:0]  basic_addr,
    input  wire logic [7:0]  ext_hi,
    input  wire logic [7:0]  ext_lo,
    input  wire logic        use_extended,
    // command address
    input  wire logic        cmd_long,
    input  wire logic [13:0] cmd_addr,
    // result
    output logic [13:0]      active_addr,
    output logic             match
);
    import dcvs_pkg::*;

    wire logic [13:0] ext_addr   = {ext_hi[EXT_HI_BITS-1:0], ext_lo};
    wire logic [13:0] basic_wide = {6'h00, basic_addr};

    // active address follows the configuration switch
    assign active_addr = use_extended ? ext_addr : basic_wide; // R9 R16
    assign match = use_extended ? (cmd_long && cmd_addr == ext_addr)
                                : (!cmd_long && cmd_addr == basic_wide); // R10
endmodule

// ==== src/dcvs_pkg.sv ====
package dcvs_pkg;

    // configuration variable numbers, counted from one
    localparam logic [9:0] CV_BASIC   = 10'h001;
    localparam logic [9:0] CV_ACCEL   = 10'h003;
    localparam logic [9:0] CV_DECEL   = 10'h004;
    localparam logic [9:0] CV_VERSION = 10'h007;
    localparam logic [9:0] CV_MAKER   = 10'h008;
    localparam logic [9:0] CV_EXT_HI  = 10'h011;
    localparam logic [9:0] CV_EXT_LO  = 10'h012;
    localparam logic [9:0] CV_CONFIG  = 10'h01D;
    localparam logic [9:0] CV_DIM     = 10'h035;
    localparam logic [9:0] CV_LAST    = 10'h100;

    // field positions inside the decoder configuration byte
    localparam int CFG_DIR_BIT    = 0;
    localparam int CFG_STEP_BIT   = 1;
    localparam int CFG_ANALOG_BIT = 2;
    localparam int CFG_CURVE_BIT  = 4;
    localparam int CFG_EXT_BIT    = 5;

    // extended address: high byte carries six address bits
    localparam int EXT_HI_BITS = 6;

    // reset values
    localparam logic [7:0] RST_BASIC  = 8'h03;
    localparam logic [7:0] RST_CONFIG = 8'h06;
    localparam logic [7:0] RST_EXT_HI = 8'hC0;
    localparam logic [7:0] RST_OTHER  = 8'h00;

    // valid basic address range
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'h63;

    // one programming command from the track receiver
    typedef struct packed {
        logic        service;    // 1: programming track, 0: main track
        logic        read;       // 1: read request, 0: write
        logic        long_addr;  // command carries a four-digit address
        logic [13:0] loco_addr;
        logic [9:0]  cv_num;
        logic [7:0]  data;
    } dcvs_cmd_t;

    // settings that steer the locomotive
    typedef struct packed {
        logic        dir_reversed;
        logic        step_128;
        logic        analog_en;
        logic        user_curve;
        logic        use_extended;
        logic [13:0] active_addr;
        logic [7:0]  accel_delay;
        logic [7:0]  decel_delay;
        logic [7:0]  dim_level;
    } dcvs_cfg_t;

endpackage

// ==== src/dcvs_store.sv ====
// Operation
// (R1) every variable holds one byte 0..255
// (R2) variable one holds basic address 1..99
// (R3) variables three/four hold acceleration/deceleration delays
// (R4) dimming variable accepts every byte value
// (R5) switch 1 reverses direction sense
// (R6) switch 2 selects 128/28 versus 14/27
// (R7) switch 3 permits analog operation
// (R8) switch 5 selects user speed curve
// (R9) switch 6 selects extended address variables
// (R10) main-track write needs matching active address
// (R11) programming-track write obeyed regardless of address
// (R12) main-track writes never change address variables
// (R13) station must be recent for main-track writes
// (R14) version and maker variables are read-only
// (R15) main-track mode only writes, never answers; obeyed main-track writes still pulse wr_done
// (R16) four-digit addresses live in extended variables
// (R17) unused switches stored, no behaviour
// (R18) out-of-range basic address write rejected
`timescale 1ns/1ps
module dcvs_store #(
    parameter logic [7:0] VERSION_ID = 8'h01, // arbitrary value
    parameter logic [7:0] MAKER_ID   = 8'h0D  // arbitrary value
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // programming command from the track receiver
    input  wire logic                 cmd_valid,
    input  wire dcvs_pkg::dcvs_cmd_t  cmd,
    // answers
    output logic                      wr_done,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    // settings
    output dcvs_pkg::dcvs_cfg_t       cfg
);
    import dcvs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] mem [0:255]; // R1

    // true when the command addresses the given variable
    function automatic logic is_cv(input logic [9:0] num, input logic [9:0] k);
        is_cv = (num == k);
    endfunction

    wire logic [7:0] cv_idx   = cmd.cv_num[7:0] - 8'h01;
    wire logic       cv_ok    = (cmd.cv_num != 10'h000) && (cmd.cv_num <= CV_LAST);
    wire logic [7:0] cv1      = mem[CV_BASIC[7:0] - 8'h01];
    wire logic [7:0] cv17     = mem[CV_EXT_HI[7:0] - 8'h01];
    wire logic [7:0] cv18     = mem[CV_EXT_LO[7:0] - 8'h01];
    wire logic [7:0] decoder_configuration     = mem[CV_CONFIG[7:0] - 8'h01];

    ////////////////////////////////////////////////////////////////////////////
    // address match
    logic [13:0] active_addr;
    logic        addr_hit;

    dcvs_addr_match u_match (
        .basic_addr   (cv1),
        .ext_hi       (cv17),
        .ext_lo       (cv18),
        .use_extended (decoder_configuration[CFG_EXT_BIT]),
        .cmd_long     (cmd.long_addr),
        .cmd_addr     (cmd.loco_addr),
        .active_addr  (active_addr),
        .match        (addr_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // write qualification
    wire logic is_addr_cv  = is_cv(cmd.cv_num, CV_BASIC) || is_cv(cmd.cv_num, CV_EXT_HI)
                             || is_cv(cmd.cv_num, CV_EXT_LO);
    wire logic is_ro_cv    = is_cv(cmd.cv_num, CV_VERSION) || is_cv(cmd.cv_num, CV_MAKER); // R14
    wire logic basic_bad   = is_cv(cmd.cv_num, CV_BASIC)
                             && (cmd.data < ADDR_MIN || cmd.data > ADDR_MAX); // R18 R2
    wire logic is_write    = cmd_valid && !cmd.read && cv_ok && !is_ro_cv && !basic_bad;
    wire logic svc_write   = is_write && cmd.service; // R11
    wire logic main_write  = is_write && !cmd.service && addr_hit && !is_addr_cv; // R10 R12
    wire logic wr_en       = svc_write || main_write;
    wire logic rd_req      = cmd_valid && cmd.read && cmd.service; // R15
    wire logic [7:0] rd_mux = !cv_ok ? 8'h00 :
                              is_cv(cmd.cv_num, CV_VERSION) ? VERSION_ID :
                              is_cv(cmd.cv_num, CV_MAKER)   ? MAKER_ID : mem[cv_idx];

    // variable store, whole bytes kept as written
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= RST_OTHER;
            end
            mem[CV_BASIC[7:0] - 8'h01]  <= RST_BASIC;
            mem[CV_EXT_HI[7:0] - 8'h01] <= RST_EXT_HI;
            mem[CV_CONFIG[7:0] - 8'h01] <= RST_CONFIG;
        end else if (wr_en) begin
            mem[cv_idx] <= cmd.data; // R1 R4 R17
        end
    end

    // answers to the station
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_done  <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            wr_done  <= wr_en;
            rd_valid <= rd_req; // R15
            if (rd_req) begin
                rd_data <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded settings
    assign cfg.dir_reversed = decoder_configuration[CFG_DIR_BIT];    // R5
    assign cfg.step_128     = decoder_configuration[CFG_STEP_BIT];   // R6
    assign cfg.analog_en    = decoder_configuration[CFG_ANALOG_BIT]; // R7
    assign cfg.user_curve   = decoder_configuration[CFG_CURVE_BIT];  // R8
    assign cfg.use_extended = decoder_configuration[CFG_EXT_BIT];    // R9
    assign cfg.active_addr  = active_addr;          // R16
    assign cfg.accel_delay  = mem[CV_ACCEL[7:0] - 8'h01]; // R3
    assign cfg.decel_delay  = mem[CV_DECEL[7:0] - 8'h01]; // R3
    assign cfg.dim_level    = mem[CV_DIM[7:0] - 8'h01];   // R4

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_svc_wr(logic [9:0] n);
        cmd_valid && cmd.service && !cmd.read && cmd.cv_num == n;
    endsequence

    sequence s_main_wr(logic [9:0] n);
        cmd_valid && !cmd.service && !cmd.read && cmd.cv_num == n;
    endsequence

    property p_main_addr_protect;
        @(posedge mclk) disable iff (!rst_n)
        (s_main_wr(CV_BASIC) or s_main_wr(CV_EXT_HI) or s_main_wr(CV_EXT_LO))
        |=> $stable(cfg.active_addr) && !wr_done;
    endproperty
    a_main_addr_protect: assert property (p_main_addr_protect) // R12
        else $error("main-track write changed an address variable");

    property p_basic_range;
        @(posedge mclk) disable iff (!rst_n)
        s_svc_wr(CV_BASIC) ##0 (cmd.data < ADDR_MIN || cmd.data > ADDR_MAX)
        |=> $stable(cv1) && !wr_done;
    endproperty
    a_basic_range: assert property (p_basic_range) // R18
        else $error("out-of-range basic address accepted");

    property p_basic_ok;
        @(posedge mclk) disable iff (!rst_n)
        s_svc_wr(CV_BASIC) ##0 (cmd.data >= ADDR_MIN && cmd.data <= ADDR_MAX)
        |=> cv1 == $past(cmd.data) && wr_done;
    endproperty
    a_basic_ok: assert property (p_basic_ok) // R2
        else $error("valid basic address not stored");

    property p_read_only;
        @(posedge mclk) disable iff (!rst_n)
        cmd_valid && cmd.service && cmd.read && cmd.cv_num == CV_VERSION
        |=> rd_valid && rd_data == VERSION_ID;
    endproperty
    a_read_only: assert property (p_read_only) // R14
        else $error("version variable read wrong value");

    property p_main_mismatch;
        @(posedge mclk) disable iff (!rst_n)
        cmd_valid && !cmd.service && !cmd.read && !addr_hit |=> !wr_done;
    endproperty
    a_main_mismatch: assert property (p_main_mismatch) // R10
        else $error("main-track write executed for another address");

    property p_svc_accel;
        @(posedge mclk) disable iff (!rst_n)
        s_svc_wr(CV_ACCEL) |=> cfg.accel_delay == $past(cmd.data) && wr_done;
    endproperty
    a_svc_accel: assert property (p_svc_accel) // R11 R3
        else $error("programming-track write to acceleration lost");

    property p_no_main_read;
        @(posedge mclk) disable iff (!rst_n)
        cmd_valid && !cmd.service && cmd.read |=> !rd_valid;
    endproperty
    a_no_main_read: assert property (p_no_main_read) // R15
        else $error("main-track read answered");

    property p_dim_full;
        @(posedge mclk) disable iff (!rst_n)
        s_svc_wr(CV_DIM) |=> cfg.dim_level == $past(cmd.data);
    endproperty
    a_dim_full: assert property (p_dim_full) // R4 R1
        else $error("dimming value not stored whole");

    property p_config_bits;
        @(posedge mclk) disable iff (!rst_n)
        s_svc_wr(CV_CONFIG) |=> cfg.dir_reversed == $past(cmd.data[0])
            && cfg.step_128 == $past(cmd.data[1]) && cfg.analog_en == $past(cmd.data[2])
            && cfg.user_curve == $past(cmd.data[4]) && cfg.use_extended == $past(cmd.data[5]);
    endproperty
    a_config_bits: assert property (p_config_bits) // R5 R6 R7 R8 R9
        else $error("configuration switches not applied");

    property p_ext_addr;
        @(posedge mclk) disable iff (!rst_n)
        s_svc_wr(CV_EXT_LO) |=> cv18 == $past(cmd.data) && wr_done;
    endproperty
    a_ext_addr: assert property (p_ext_addr) // R16
        else $error("extended address byte not stored");

    // a short-address main-track write is never obeyed by a decoder in extended mode
    property p_ext_short;
        @(posedge mclk) disable iff (!rst_n)
        cfg.use_extended && cmd_valid && !cmd.service && !cmd.read && !cmd.long_addr
        |=> !wr_done;
    endproperty
    a_ext_short: assert property (p_ext_short) // R9
        else $error("short-address command obeyed in extended mode");
endmodule

// ==== verification/dcvs_station.sv ====
`timescale 1ns/1ps
module dcvs_station #(
    parameter int SW_VERSION = 3
) (
    // clock
    input  wire logic           mclk,
    // command towards the decoder
    output dcvs_pkg::dcvs_cmd_t cmd,
    output logic                cmd_valid
);
    import dcvs_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end
    // one command per cycle, launched on the falling edge
    task automatic send(input logic svc, rd, lng, input logic [13:0] a,
                        input logic [9:0] n, input logic [7:0] d);
        @(negedge mclk);
        cmd_valid = svc | rd | (SW_VERSION >= 3);
        cmd       = '{svc, rd, lng, a, n, d};
    endtask
    // released lines carry a changing pattern, never the last command
    task automatic idle();
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd       = ~cmd;
    endtask
endmodule

// ==== verification/tb_decoder_cv_store.sv ====
`timescale 1ns/1ps
module tb_decoder_cv_store;
    import dcvs_pkg::*;
    localparam logic [7:0] VER = 8'h01; // arbitrary value
    localparam logic [7:0] MKR = 8'h0D; // arbitrary value
    logic        mclk;
    logic        rst_n;
    logic        cmd_valid;
    dcvs_cmd_t   cmd;
    logic        wr_done;
    logic        rd_valid;
    logic [7:0]  rd_data;
    dcvs_cfg_t   cfg;
    logic [8:0]  exp_q[$];
    logic [8:0]  got;
    logic [8:0]  ans;
    logic [4:0]  sw;
    logic [31:0] seed;
    logic [7:0]  v;
    int          err_total;
    int          n_checks;

    dcvs_store #(.VERSION_ID(VER), .MAKER_ID(MKR)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .wr_done(wr_done),
        .rd_valid(rd_valid), .rd_data(rd_data), .cfg(cfg));
    dcvs_station #(.SW_VERSION(3)) u_stn (.mclk(mclk), .cmd(cmd), .cmd_valid(cmd_valid));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // write; an obeyed write leaves a note for the monitor
    task automatic wr(input logic svc, lng, input logic [13:0] a, input logic [9:0] n,
                      input logic [7:0] d, input logic ok);
        u_stn.send(svc, 1'b0, lng, a, n, d);
        if (ok) begin
            exp_q.push_back(9'h000);
        end
    endtask
    // programming-track read with its expected answer
    task automatic rd(input logic [9:0] n, input logic [7:0] d);
        u_stn.send(1'b1, 1'b1, 1'b0, 14'h0000, n, 8'h00);
        exp_q.push_back({1'b1, d});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // every answer is matched against the oldest note
    always @(negedge mclk) begin
        if (rst_n === 1'b1 && (wr_done | rd_valid) !== 1'b0) begin
            got = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
            ans = {rd_valid, rd_valid ? rd_data : 8'h00};
            check("answer", {7'h00, ans}, {7'h00, got});
        end
    end
    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #8000;
        err_total++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        n_checks  = 0;
        seed      = 32'h9B916B26;
        rst_n     = 1'b0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        check("rst_addr", 16'(cfg.active_addr), 16'h0003);
        rd(CV_CONFIG, 8'h06);
        // delays and dimming take any byte, delay boundaries included
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 8'h00 : (i == 3) ? 8'hFF : seed[7:0];
            wr(1'b1, 1'b0, 14'h0000, CV_ACCEL, v, 1'b1);
            wr(1'b1, 1'b0, 14'h0000, CV_DECEL, ~v, 1'b1);
            wr(1'b1, 1'b0, 14'h0000, CV_DIM, v ^ 8'h5A, 1'b1);
            rd(CV_DIM, v ^ 8'h5A);
            u_stn.idle();
            check("accel", 16'(cfg.accel_delay), 16'(v));
            check("decel", 16'(cfg.decel_delay), {8'h00, ~v});
            check("dim", 16'(cfg.dim_level), 16'(v ^ 8'h5A));
        end
        // each configuration switch alone
        for (int b = 0; b < 8; b++) begin
            v = 8'h01 << b;
            wr(1'b1, 1'b0, 14'h0000, CV_CONFIG, v, 1'b1);
            rd(CV_CONFIG, v);
            u_stn.idle();
            sw = {cfg.dir_reversed, cfg.step_128, cfg.analog_en, cfg.user_curve, cfg.use_extended};
            check("cfg_bits", 16'(sw), 16'({v[0], v[1], v[2], v[4], v[5]}));
        end
        wr(1'b1, 1'b0, 14'h0000, CV_CONFIG, 8'h06, 1'b1);
        wr(1'b1, 1'b0, 14'h0000, CV_BASIC, 8'h00, 1'b0);
        wr(1'b1, 1'b0, 14'h0000, CV_BASIC, 8'h64, 1'b0);
        wr(1'b1, 1'b0, 14'h0000, CV_BASIC, 8'h63, 1'b1);
        rd(CV_BASIC, 8'h63);
        wr(1'b1, 1'b0, 14'h0000, CV_BASIC, 8'h01, 1'b1);
        wr(1'b1, 1'b0, 14'h0000, CV_VERSION, 8'h55, 1'b0);
        wr(1'b1, 1'b0, 14'h0000, CV_MAKER, 8'h55, 1'b0);
        rd(CV_VERSION, VER);
        rd(CV_MAKER, MKR);
        rd(10'h0C8, 8'h00);
        // numbers outside 1..256 are never stored, reads of them give zero
        rd(10'h101, 8'h00);
        wr(1'b1, 1'b0, 14'h0000, 10'h000, 8'h55, 1'b0);
        wr(1'b1, 1'b0, 14'h0000, 10'h101, 8'h55, 1'b0);
        // main track: only the matching decoder obeys, address variables stay
        wr(1'b0, 1'b0, 14'h0001, CV_ACCEL, 8'h21, 1'b1);
        wr(1'b0, 1'b0, 14'h0002, CV_ACCEL, 8'h99, 1'b0);
        wr(1'b0, 1'b1, 14'h0001, CV_ACCEL, 8'h99, 1'b0);
        wr(1'b0, 1'b0, 14'h0001, CV_BASIC, 8'h05, 1'b0);
        wr(1'b0, 1'b0, 14'h0001, CV_EXT_LO, 8'h05, 1'b0);
        u_stn.send(1'b0, 1'b1, 1'b0, 14'h0001, CV_ACCEL, 8'h00);
        u_stn.idle();
        check("basic", 16'(cfg.active_addr), 16'h0001);
        check("pom_accel", 16'(cfg.accel_delay), 16'h0021);
        // four-digit address in the extended pair
        wr(1'b1, 1'b0, 14'h0000, CV_EXT_HI, 8'hC4, 1'b1);
        wr(1'b1, 1'b0, 14'h0000, CV_EXT_LO, 8'hD2, 1'b1);
        wr(1'b1, 1'b0, 14'h0000, CV_CONFIG, 8'h26, 1'b1);
        wr(1'b0, 1'b1, 14'h04D2, CV_DECEL, 8'h42, 1'b1);
        wr(1'b0, 1'b0, 14'h0001, CV_DECEL, 8'h77, 1'b0);
        wr(1'b0, 1'b1, 14'h04D2, CV_EXT_HI, 8'h00, 1'b0);
        u_stn.idle();
        check("ext_addr", 16'(cfg.active_addr), 16'h04D2);
        check("pom_decel", 16'(cfg.decel_delay), 16'h0042);
        repeat (3) @(negedge mclk);
        check("pending", 16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule
